// >>> rtl/lrd_defines.svh
// Offsets, field positions, reset values and region constants
`ifndef LRD_DEFINES_SVH
`define LRD_DEFINES_SVH
`define LRD_CFG_OFF 8'h00
`define LRD_STAT_OFF 8'h04
`define LRD_HITS_OFF 8'h08
`define LRD_CFG_PRIM_LSB 0
`define LRD_CFG_SEC_LSB 4
`define LRD_CFG_LINK_LSB 8
`define LRD_STAT_ROMWR_BIT 8
`define LRD_PRIM_RST 2'h1
`define LRD_SEC_RST 3'h1
`define LRD_LINK_RST 6'h00
`define LRD_TOP_PV 25'h1000000
`define LRD_TOP_RA 25'h0100000
`define LRD_LOW_SPLIT_PV 25'h0fc0000
`define LRD_LOW_SPLIT_RA 25'h00c0000
`define LRD_EXP_LIM_PV 25'h0e00000
`define LRD_EXP_LIM_RA_LO 25'h00e0000
`define LRD_EXP_LIM_RA_HI 25'h00a0000
`endif

// >>> rtl/lrd_pkg.sv
// Types shared by the local memory decoder modules
package lrd_pkg;
    typedef enum logic [1:0] {
        LRD_TGT_SYSBUS = 2'b00,
        LRD_TGT_EXP = 2'b01,
        LRD_TGT_LOWER = 2'b10,
        LRD_TGT_UPPER = 2'b11
    } lrd_target_t;
    typedef enum logic [1:0] {
        LRD_ST_IDLE = 2'b00,
        LRD_ST_LOCAL = 2'b01,
        LRD_ST_REMOTE = 2'b10
    } lrd_state_t;
endpackage

// >>> rtl/lrd_dec_if.sv
// Address decode request and result between top and map decoder
`timescale 1ns/1ps
interface lrd_dec_if;
    logic [23:0] addr;
    logic protected_virtual_mode;
    logic [1:0] prim;
    logic [2:0] sec;
    logic hit_upper;
    logic hit_lower;
    logic hit_exp;
    logic [24:0] upper_base;
    logic [24:0] lower_base;
    modport requester (output addr, protected_virtual_mode, prim, sec,
        input hit_upper, hit_lower, hit_exp, upper_base, lower_base);
    modport decoder (input addr, protected_virtual_mode, prim, sec,
        output hit_upper, hit_lower, hit_exp, upper_base, lower_base);
endinterface

// >>> rtl/lrd_map_dec.sv
// Primary and secondary memory map decoder for the two rom pairs
`timescale 1ns/1ps
`include "lrd_defines.svh"
module lrd_map_dec
    import lrd_pkg::*;
(
    lrd_dec_if.decoder dec
);
    wire pv = dec.protected_virtual_mode;
    wire split = dec.sec[2];
    wire [24:0] top1 = pv ? `LRD_TOP_PV : `LRD_TOP_RA;
    wire [24:0] a = pv ? {1'b0, dec.addr} : {5'h00, dec.addr[19:0]};
    logic [24:0] usize;
    logic [24:0] lsize;
    // Upper pair always ends at the top of the mode's space
    always_comb
    begin
        case (dec.prim)
            2'h0: usize = 25'h0004000;
            2'h1: usize = 25'h0008000;
            2'h2: usize = 25'h0010000;
            default: usize = pv ? 25'h0020000 : 25'h0010000;
        endcase
    end
    always_comb
    begin
        if (split)
        begin
            case (dec.sec[1:0])
                2'h0: lsize = 25'h0001000;
                2'h1: lsize = 25'h0004000;
                2'h2: lsize = 25'h0008000;
                default: lsize = 25'h0010000;
            endcase
        end
        else
        begin
            case (dec.prim)
                2'h0: lsize = 25'h000c000;
                2'h1: lsize = 25'h0008000;
                2'h2: lsize = 25'h0030000;
                default: lsize = pv ? 25'h0020000 : 25'h0030000;
            endcase
        end
    end
    wire [24:0] ubase = top1 - usize;
    wire [24:0] split_base = pv ? `LRD_LOW_SPLIT_PV : `LRD_LOW_SPLIT_RA;
    wire [24:0] lbase = split ? split_base : ubase - lsize;
    wire [24:0] lend = lbase + lsize;
    wire [24:0] exp_ra = dec.prim[1] ? `LRD_EXP_LIM_RA_HI : `LRD_EXP_LIM_RA_LO;
    wire [24:0] exp_lim = pv ? `LRD_EXP_LIM_PV : exp_ra;
    wire in_up = (a >= ubase) && (a < top1);
    wire in_lo = (a >= lbase) && (a < lend) && !in_up;
    assign dec.hit_upper = in_up;
    assign dec.hit_lower = in_lo;
    assign dec.hit_exp = (a < exp_lim) && !in_up && !in_lo;
    assign dec.upper_base = ubase;
    assign dec.lower_base = lbase;
endmodule // lrd_map_dec

// >>> rtl/lrd_wait_gen.sv
// Wait-state counter for one local memory cycle
`timescale 1ns/1ps
module lrd_wait_gen
    import lrd_pkg::*;
#(
    parameter int CW = 2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [CW-1:0] waits,
    output logic busy,
    output logic done
);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_busy;
    wire last = busy && (count == {CW{1'b0}});
    assign next_busy = start | (busy & !last);
    assign next_count = start ? waits - {{(CW-1){1'b0}}, 1'b1} :
        (busy ? count - {{(CW-1){1'b0}}, 1'b1} : count);
    assign done = last;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy <= 1'b0;
            count <= '0;
        end
        else
        begin
            busy <= next_busy;
            count <= next_count;
        end
    end
endmodule // lrd_wait_gen

// >>> rtl/lrd_top.sv
// Local rom address decode and wait-state control with register port
//
// Notes on behaviour
// - Two strap bits pick one of four maps
// - Option three upper pair: 128K protected, 64K real
// - Option three lower pair sits directly below upper
// - Option three expansion region: 14M protected, 640K real
// - Three secondary bits, highest pair most significant
// - Secondary option sets socket sizes per pair
// - Options zero to three: lower pair contiguous
// - Options four to seven: lower pair fixed base
// - Upper pair always ends at top of memory
// - Smaller devices alias within the decoded range
// - Even bytes one socket, odd bytes the other
// - Both local pairs are read-only memory
// - Local hits insert per-pair one to three waits
// - Wait-state links decode to per-pair counts
// - Default straps: option one, one wait each
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "lrd_defines.svh"
module lrd_top
    import lrd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cpu_req,
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_bhe_n,
    input wire logic cpu_write,
    input wire logic protected_virtual_mode,
    output logic cpu_ready,
    output logic upper_rom_pair_sel,
    output logic lower_rom_pair_sel,
    output logic exp_bus_sel,
    output logic sysbus_sel,
    output logic rom_even_cs,
    output logic rom_odd_cs,
    output logic [15:0] rom_word_addr,
    input wire logic ext_ready
);
    // Configuration straps held in a register
    logic [1:0] prim;
    logic [2:0] sec;
    logic [5:0] links;
    logic rom_write_seen;
    logic [15:0] upper_hits;
    logic [15:0] lower_hits;
    lrd_target_t last_target;

    // AHB-Lite address phase capture
    logic dph_write;
    logic [7:0] dph_addr;
    wire ahb_go = hsel && hready && htrans[1];
    wire [7:0] aoff = haddr[7:0];

    function automatic logic [31:0] reg_read(input logic [7:0] off,
        input logic [31:0] cfg, input logic [31:0] stat,
        input logic [31:0] hits);
        logic [31:0] v;
        v = 32'h00000000;
        case (off)
            `LRD_CFG_OFF: v = cfg;
            `LRD_STAT_OFF: v = stat;
            `LRD_HITS_OFF: v = hits;
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    // Wait-state link decode: upper pair count, lower pair count
    function automatic logic [3:0] wait_decode(input logic [5:0] l);
        logic w_178_181;
        logic w_178_179;
        logic w_179_180;
        logic w_180_181;
        logic w_177_178;
        logic w_177_180;
        logic [1:0] up;
        logic [1:0] lo;
        w_177_180 = l[0];
        w_177_178 = l[1];
        w_179_180 = l[2];
        w_180_181 = l[3];
        w_178_179 = l[4];
        w_178_181 = l[5];
        if (w_178_181 || w_178_179)
            up = 2'h3;
        else if (w_179_180 || w_180_181)
            up = 2'h2;
        else
            up = 2'h1;
        if (w_178_181 || w_177_178)
            lo = 2'h3;
        else if (w_180_181 || w_177_180)
            lo = 2'h2;
        else
            lo = 2'h1;
        return {up, lo};
    endfunction

    wire [3:0] wcounts = wait_decode(links);
    wire [1:0] upper_waits = wcounts[3:2];
    wire [1:0] lower_waits = wcounts[1:0];

    wire [31:0] cfg_word = {18'h00000, links, 1'b0, sec, 2'h0, prim};
    wire [31:0] stat_word = {23'h000000, rom_write_seen, lower_waits,
        upper_waits, 2'h0, last_target};
    wire [31:0] hits_word = {upper_hits, lower_hits};
    wire [31:0] rd_value = reg_read(aoff, cfg_word, stat_word, hits_word);

    wire wr_cfg = dph_write && (dph_addr == `LRD_CFG_OFF);
    wire wr_stat = dph_write && (dph_addr == `LRD_STAT_OFF);
    wire wr_hits = dph_write && (dph_addr == `LRD_HITS_OFF);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dph_write <= 1'b0;
            dph_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            dph_write <= ahb_go && hwrite;
            dph_addr <= aoff;
            if (ahb_go && !hwrite)
                hrdata <= rd_value;
        end
    end

    // Defaults give option one/one and one wait per pair
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prim <= `LRD_PRIM_RST;
            sec <= `LRD_SEC_RST;
            links <= `LRD_LINK_RST;
        end
        else if (wr_cfg)
        begin
            prim <= hwdata[`LRD_CFG_PRIM_LSB +: 2];
            sec <= hwdata[`LRD_CFG_SEC_LSB +: 3];
            links <= hwdata[`LRD_CFG_LINK_LSB +: 6];
        end
    end

    // Processor cycle capture
    lrd_state_t state;
    lrd_state_t next_state;
    logic [23:0] cyc_addr;
    logic cyc_bhe_n;
    logic cyc_write;

    lrd_dec_if dec ();
    assign dec.addr = cpu_addr;
    assign dec.protected_virtual_mode = protected_virtual_mode;
    assign dec.prim = prim;
    assign dec.sec = sec;

    lrd_map_dec u_map (
        .dec(dec)
    );

    wire take = (state == LRD_ST_IDLE) && cpu_req;
    wire local_hit = dec.hit_upper || dec.hit_lower;
    lrd_target_t dec_target;
    assign dec_target = dec.hit_upper ? LRD_TGT_UPPER :
        (dec.hit_lower ? LRD_TGT_LOWER :
        (dec.hit_exp ? LRD_TGT_EXP : LRD_TGT_SYSBUS));
    wire [1:0] pick_waits = dec.hit_upper ? upper_waits : lower_waits;

    logic wg_busy;
    logic wg_done;
    lrd_wait_gen #(
        .CW(2)
    ) u_wait (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(take && local_hit),
        .waits(pick_waits),
        .busy(wg_busy),
        .done(wg_done)
    );

    always_comb
    begin
        case (state)
            LRD_ST_IDLE:
                if (take)
                    next_state = local_hit ? LRD_ST_LOCAL : LRD_ST_REMOTE;
                else
                    next_state = LRD_ST_IDLE;
            LRD_ST_LOCAL:
                next_state = wg_done ? LRD_ST_IDLE : LRD_ST_LOCAL;
            LRD_ST_REMOTE:
                next_state = ext_ready ? LRD_ST_IDLE : LRD_ST_REMOTE;
            default:
                next_state = LRD_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= LRD_ST_IDLE;
            last_target <= LRD_TGT_SYSBUS;
            cyc_addr <= 24'h000000;
            cyc_bhe_n <= 1'b1;
            cyc_write <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (take)
            begin
                last_target <= dec_target;
                cyc_addr <= cpu_addr;
                cyc_bhe_n <= cpu_bhe_n;
                cyc_write <= cpu_write;
            end
        end
    end

    // Target selects stand for the whole cycle
    wire in_local = (state == LRD_ST_LOCAL);
    wire in_remote = (state == LRD_ST_REMOTE);
    assign upper_rom_pair_sel = in_local && (last_target == LRD_TGT_UPPER);
    assign lower_rom_pair_sel = in_local && (last_target == LRD_TGT_LOWER);
    assign exp_bus_sel = in_remote && (last_target == LRD_TGT_EXP);
    assign sysbus_sel = in_remote && (last_target == LRD_TGT_SYSBUS);
    // Remote cycles see no local wait states
    assign cpu_ready = (in_local && wg_done) || (in_remote && ext_ready);

    // Roms never see a write strobe; a write cycle still completes
    wire rom_rd = in_local && !cyc_write;
    assign rom_even_cs = rom_rd && !cyc_addr[0];
    assign rom_odd_cs = rom_rd && (cyc_addr[0] || !cyc_bhe_n);

    // Socket size sets how many word address bits reach the devices
    logic [15:0] sock_mask;
    always_comb
    begin
        if (dec.hit_upper && sec[2])
            sock_mask = 16'hffff;
        else
        begin
            case (sec[1:0])
                2'h0: sock_mask = sec[2] ? 16'h07ff : 16'h1fff;
                2'h1: sock_mask = sec[2] ? 16'h1fff : 16'h3fff;
                2'h2: sock_mask = sec[2] ? 16'h3fff : 16'h7fff;
                default: sock_mask = sec[2] ? 16'h7fff : 16'hffff;
            endcase
        end
    end
    // Built from the live request so the address stands from the first cycle
    wire [24:0] req_a = protected_virtual_mode ? {1'b0, cpu_addr} :
        {5'h00, cpu_addr[19:0]};
    wire [24:0] pair_base = dec.hit_upper ? dec.upper_base : dec.lower_base;
    wire [24:0] pair_off = req_a - pair_base;
    // Upper address bits dropped, so small devices repeat
    wire [15:0] word_off = pair_off[16:1] & sock_mask;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rom_word_addr <= 16'h0000;
        else if (take)
            rom_word_addr <= word_off;
    end

    // Write to rom is flagged; a new event wins over the clear
    wire romwr_evt = take && local_hit && cpu_write;
    wire romwr_clr = wr_stat && hwdata[`LRD_STAT_ROMWR_BIT];
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rom_write_seen <= 1'b0;
        else if (romwr_evt)
            rom_write_seen <= 1'b1;
        else if (romwr_clr)
            rom_write_seen <= 1'b0;
    end

    wire up_evt = take && dec.hit_upper;
    wire lo_evt = take && dec.hit_lower;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            upper_hits <= 16'h0000;
            lower_hits <= 16'h0000;
        end
        else if (wr_hits)
        begin
            upper_hits <= up_evt ? 16'h0001 : 16'h0000;
            lower_hits <= lo_evt ? 16'h0001 : 16'h0000;
        end
        else
        begin
            if (up_evt)
                upper_hits <= upper_hits + 16'h0001;
            if (lo_evt)
                lower_hits <= lower_hits + 16'h0001;
        end
    end
endmodule // lrd_top

// >>> test/lrd_chk.sv
// Port checker for the local rom decoder
`timescale 1ns/1ps
module lrd_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cpu_req,
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_bhe_n,
    input wire logic cpu_write,
    input wire logic cpu_ready,
    input wire logic upper_rom_pair_sel,
    input wire logic lower_rom_pair_sel,
    input wire logic exp_bus_sel,
    input wire logic sysbus_sel,
    input wire logic rom_even_cs,
    input wire logic rom_odd_cs,
    input wire logic ext_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic loc_w = upper_rom_pair_sel | lower_rom_pair_sel;
    wire logic rem_w = exp_bus_sel | sysbus_sel;
    wire logic busy_w = loc_w | rem_w;
    wire logic cs_w = rom_even_cs | rom_odd_cs;
    wire logic [3:0] sel_w = {upper_rom_pair_sel, lower_rom_pair_sel,
        exp_bus_sel, sysbus_sel};
    one_target_a:
    assert property ($onehot0(sel_w)) else $error("two targets selected");
    take_sel_a:
    assert property (cpu_req && !busy_w |=> busy_w)
        else $error("request not taken");
    local_wait_a:
    assert property ($rose(loc_w) |-> ##[0:2] cpu_ready)
        else $error("local cycle too long");
    remote_ready_a:
    assert property (rem_w |-> cpu_ready == ext_ready)
        else $error("remote ready not passed");
    sel_hold_a:
    assert property (busy_w && !cpu_ready |=> $stable(sel_w))
        else $error("select dropped early");
    ready_busy_a:
    assert property (cpu_ready |-> busy_w) else $error("stray ready");
    cs_local_a:
    assert property (cs_w |-> loc_w) else $error("chip select off rom");
    rom_write_a:
    assert property (cpu_req && cpu_write && !busy_w |=> !cs_w [*2])
        else $error("chip select on write");
    byte_lane_a:
    assert property ($rose(cs_w) |-> rom_even_cs == !$past(cpu_addr[0])
        && rom_odd_cs == ($past(cpu_addr[0]) || !$past(cpu_bhe_n)))
        else $error("wrong byte lane");
    cov_upper: cover property ($rose(upper_rom_pair_sel));
    cov_lower: cover property ($rose(lower_rom_pair_sel));
    cov_stall: cover property (rem_w && !ext_ready);
endmodule // lrd_chk
bind lrd_top lrd_chk chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_bhe_n(cpu_bhe_n),
    .cpu_write(cpu_write), .cpu_ready(cpu_ready),
    .upper_rom_pair_sel(upper_rom_pair_sel),
    .lower_rom_pair_sel(lower_rom_pair_sel), .exp_bus_sel(exp_bus_sel),
    .sysbus_sel(sysbus_sel), .rom_even_cs(rom_even_cs),
    .rom_odd_cs(rom_odd_cs), .ext_ready(ext_ready));

// >>> test/lrd_cpu_model.sv
// Processor model issuing memory cycles, also the remote ready source
`timescale 1ns/1ps
module lrd_cpu_model (
    input wire logic clk_sys,
    input wire logic cpu_ready,
    input wire logic [3:0] sels,
    output logic cpu_req,
    output logic [23:0] cpu_addr,
    output logic cpu_bhe_n,
    output logic cpu_write,
    output logic protected_virtual_mode,
    output logic ext_ready
);
    initial
    begin
        cpu_req = 0;
        cpu_addr = 0;
        cpu_bhe_n = 1;
        cpu_write = 0;
        protected_virtual_mode = 0;
        ext_ready = 0;
    end
    task automatic run(input logic [23:0] a, input logic pv, wr, bn,
        input int dly, output int lat, output logic [3:0] t);
        cpu_req <= 1;
        cpu_addr <= a;
        protected_virtual_mode <= pv;
        cpu_write <= wr;
        cpu_bhe_n <= bn;
        @(posedge clk_sys);
        cpu_req <= 0;
        // Released lines carry junk, not the old value
        cpu_addr <= ~a;
        cpu_bhe_n <= ~bn;
        cpu_write <= ~wr;
        t = 4'h0;
        for (lat = 1; lat < 20; lat++)
        begin
            ext_ready <= lat > dly;
            @(negedge clk_sys);
            if (lat == 1)
                t = sels;
            if (cpu_ready === 1'b1)
                break;
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
        ext_ready <= 0;
    endtask
endmodule // lrd_cpu_model

// >>> test/lrd_tb_top.sv
// Random and corner tests of the local rom decoder
`timescale 1ns/1ps
module local_rom_decode_waitstate_tb_top;
    logic clk_sys = 0;
    logic reset_n = 0;
    logic hsel = 0;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [2:0] hsize = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cpu_req, cpu_bhe_n, cpu_write, pvm, cpu_ready;
    logic usel, lsel, esel, ssel, ext_ready;
    logic [23:0] cpu_addr;
    logic [15:0] wa;
    int failures = 0;
    int tests_run = 0;
    int seed = 16;
    always #20 clk_sys = ~clk_sys;
    lrd_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_req(cpu_req),
        .cpu_addr(cpu_addr), .cpu_bhe_n(cpu_bhe_n), .cpu_write(cpu_write),
        .protected_virtual_mode(pvm), .cpu_ready(cpu_ready),
        .upper_rom_pair_sel(usel), .lower_rom_pair_sel(lsel),
        .exp_bus_sel(esel), .sysbus_sel(ssel), .rom_even_cs(),
        .rom_odd_cs(), .rom_word_addr(wa), .ext_ready(ext_ready));
    lrd_cpu_model CPU (.clk_sys(clk_sys), .cpu_ready(cpu_ready),
        .sels({usel, lsel, esel, ssel}), .cpu_req(cpu_req),
        .cpu_addr(cpu_addr), .cpu_bhe_n(cpu_bhe_n), .cpu_write(cpu_write),
        .protected_virtual_mode(pvm), .ext_ready(ext_ready));
    task automatic check(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Upper waits in [3:2], lower in [1:0]
    function automatic logic [3:0] wts(logic [31:0] c);
        logic [1:0] u, l;
        u = (c[12] | c[13]) ? 2'h3 : (c[10] | c[11]) ? 2'h2 : 2'h1;
        l = (c[9] | c[13]) ? 2'h3 : (c[11] | c[8]) ? 2'h2 : 2'h1;
        return {u, l};
    endfunction
    function automatic logic [1:0] tgt(logic [31:0] c, logic pv,
        logic [23:0] a);
        logic [24:0] x, ub, lb, lt, el;
        x = pv ? {1'b0, a} : {5'h0, a[19:0]};
        ub = pv ? 25'h1000000 : 25'h0100000;
        case (c[1:0])
            0: ub = ub - 25'h4000;
            1: ub = ub - 25'h8000;
            2: ub = ub - 25'h10000;
            default: ub = ub - (pv ? 25'h20000 : 25'h10000);
        endcase
        case (c[1:0])
            0: lb = ub - 25'hc000;
            1: lb = ub - 25'h8000;
            2: lb = ub - 25'h30000;
            default: lb = ub - (pv ? 25'h20000 : 25'h30000);
        endcase
        lt = ub;
        if (c[6])
        begin
            lb = pv ? 25'hfc0000 : 25'h0c0000;
            lt = lb + (c[5:4] == 0 ? 25'h1000 : 25'h4000 << (c[5:4] - 1));
        end
        el = pv ? 25'he00000 : (c[1] ? 25'h0a0000 : 25'h0e0000);
        return x >= ub ? 2'h3 : (x >= lb && x < lt) ? 2'h2 :
            x < el ? 2'h1 : 2'h0;
    endfunction
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        stop_test();
    end
    initial
    begin
        logic [31:0] rd, c;
        logic [23:0] a, off;
        logic [3:0] t, w;
        logic [1:0] e;
        logic pv;
        int lat, d, n;
        // Matched options zero to three, then primary three with secondary four to seven, then option one with three waits per pair
        logic [31:0] cfgs [9];
        cfgs = '{32'h0000, 32'h0111, 32'h0222, 32'h0433,
            32'h0843, 32'h0653, 32'h1063, 32'h1173, 32'h2011};
        repeat (10) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        ahb(0, 8'h00, 0, rd);
        check("cfg", rd, 32'h11);
        ahb(0, 8'h04, 0, rd);
        check("stat", rd, 32'h50);
        ahb(0, 8'h0c, 0, rd);
        check("unmapped", rd, 32'h0);
        CPU.run(24'h0ffff0, 0, 0, 1, 99, lat, t);
        check("def lat", lat, 1);
        check("def tgt", t, 4'h8);
        check("word addr", wa, 16'h3ff8);
        foreach (cfgs[i])
        begin
            c = cfgs[i];
            w = wts(c);
            ahb(1, 8'h00, c, rd);
            ahb(0, 8'h00, 0, rd);
            check("cfg rb", rd, c);
            for (n = 0; n < 40; n++)
            begin
                rd = $random(seed);
                pv = rd[31];
                off = rd[30] ? {6'h0, rd[17:0]} : rd[23:0];
                a = (pv ? 24'hffffff : 24'h0fffff) - off;
                if (!pv)
                    a[23:20] = 4'h0;
                e = tgt(c, pv, a);
                d = e[1] ? 99 : rd[29:28];
                CPU.run(a, pv, 0, rd[27], d, lat, t);
                check("tgt", t, 4'h1 << e);
                check("lat", lat, e == 3 ? w[3:2] : e == 2 ? w[1:0] : d + 1);
            end
            ahb(0, 8'h04, 0, rd);
            check("stat", {rd[5:4], rd[7:6], rd[1:0]}, {w, e});
        end
        CPU.run(24'h0ffff1, 0, 1, 0, 99, lat, t);
        check("rom wr lat", lat, 3);
        check("rom wr addr", wa, 16'h3ff8);
        ahb(0, 8'h04, 0, rd);
        check("rom wr", rd[8], 1);
        ahb(1, 8'h04, 32'h100, rd);
        ahb(0, 8'h04, 0, rd);
        check("rom wr clr", rd[8], 0);
        stop_test();
    end
endmodule // local_rom_decode_waitstate_tb_top
